//--- rtl/lsr_core.sv
// register file, integration timing and threshold interrupt of a light sensor
// assumes an upstream serial slave turns bus frames into single-cycle register
// strobes on clk_sys_i; osc_clk_i is the free-running conversion oscillator
//
// Contract
// - flag in control bit 5 sets on threshold trigger, host writing zero clears it.
// - gain field bits 3:2 picks one of four increasing range constants.
// - oscillator counts at half rate for gain codes 0,1, full rate otherwise.
// - flag and pin assert after m consecutive out-of-window integrations, m=1,4,8,16.
// - upper threshold resets to ff and is high byte of 16-bit limit.
// - lower threshold resets to 00 and is high byte of 16-bit limit.
// - result registers refresh with new conversion at every integration end.
// - result low byte reads at 04, high byte at 05.
// - timer count reads low at 06, high at 07, meaningful in external timing.
// - timer counts oscillator cycles during integration, latched at period end.
// - width setting fixes internal integration length at 2^n oscillator cycles.
// - full scale is 2^n internally, the latched timer count externally.
// - width codes 0..3 select 65536, 4096, 256, 16 cycles.
// - write with address bit 6 set clears the pending interrupt.
// - external timing: write with address bit 7 set ends and restarts integration.
// - addresses 04 to 07 are read-only; writes there do nothing.
`timescale 1ns/10ps

module lsr_core
	import lsr_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        osc_clk_i,
	input  wire logic [15:0] conv_data_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             int_pin_o,
	output logic             int_pin_oe_n_o,
	output logic      [16:0] range_const_o,
	output logic      [16:0] full_scale_span_o,
	output logic             conv_done_o
);

	logic [7:0]     cmd_q;
	logic [3:0]     ctrl_q;
	logic           flag_q;
	logic [7:0]     upper_q;
	logic [7:0]     lower_q;
	logic [15:0]    result_q;
	logic [15:0]    timer_q;
	logic [15:0]    cyc_q;
	logic           half_q;
	logic [4:0]     pers_q;
	lsr_win_state_t win_q;
	logic           osc_s1_q;
	logic           osc_s2_q;
	logic           osc_s3_q;
	logic [7:0]     rdata_q;
	logic           done_q;

	logic           osc_edge;
	logic           osc_tick;
	logic           ext_mode;
	logic           sync_wr;
	logic           clear_wr;
	logic           plain_wr;
	logic           int_end;
	logic           ext_end;
	logic           conv_end;
	logic [16:0]    int_len;
	logic [15:0]    upper_lim;
	logic [15:0]    lower_lim;
	logic           outside;
	logic [4:0]     pers_need;
	logic [4:0]     pers_next;
	logic           trigger;
	logic           ctrl_clr;

	function automatic logic [16:0] width_len(input logic [1:0] code);
		case (code)
			2'b00:   width_len = LSR_LEN_0;
			2'b01:   width_len = LSR_LEN_1;
			2'b10:   width_len = LSR_LEN_2;
			default: width_len = LSR_LEN_3;
		endcase
	endfunction

	function automatic logic [4:0] pers_count(input logic [1:0] code);
		case (code)
			2'b00:   pers_count = LSR_PERS_0;
			2'b01:   pers_count = LSR_PERS_1;
			2'b10:   pers_count = LSR_PERS_2;
			default: pers_count = LSR_PERS_3;
		endcase
	endfunction

	function automatic logic [16:0] range_of(input logic [1:0] code);
		case (code)
			2'b00:   range_of = LSR_RANGE_0;
			2'b01:   range_of = LSR_RANGE_1;
			2'b10:   range_of = LSR_RANGE_2;
			default: range_of = LSR_RANGE_3;
		endcase
	endfunction

	// oscillator edge detection after two-flop synchroniser
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end
		else
		begin
			osc_s1_q <= osc_clk_i;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	assign osc_edge = osc_s2_q & ~osc_s3_q;

	// low ranges take every second oscillator edge
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			half_q <= 1'b0;
		else if (osc_edge)
			half_q <= ~half_q;
	end

	assign osc_tick = osc_edge & cmd_q[LSR_CMD_ENABLE]
	                  & (ctrl_q[LSR_CTRL_GAIN_LO+1] | half_q);

	// write decode
	assign ext_mode = cmd_q[LSR_CMD_EXT_TIME];
	assign sync_wr  = reg_wr_i & reg_addr_i[LSR_SYNC_BIT];
	assign clear_wr = reg_wr_i & reg_addr_i[LSR_CLEAR_BIT];
	assign plain_wr = reg_wr_i & ~reg_addr_i[LSR_SYNC_BIT] & ~reg_addr_i[LSR_CLEAR_BIT];
	// control write with the flag bit low
	assign ctrl_clr = plain_wr & (reg_addr_i == LSR_ADDR_CTRL) & ~reg_wdata_i[LSR_CTRL_FLAG];

	// integration end
	assign int_len  = width_len(cmd_q[LSR_CMD_WIDTH_LO +: 2]);
	assign int_end  = ~ext_mode & osc_tick
	                  & ({1'b0, cyc_q} == int_len - 17'd1);
	assign ext_end  = ext_mode & sync_wr;
	assign conv_end = int_end | ext_end;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			cyc_q <= 16'h0000;
		else if (conv_end)
			cyc_q <= 16'h0000;
		else if (osc_tick)
			cyc_q <= cyc_q + 16'h0001;
	end

	// latched timer and result
	// an internal end counts its own closing tick
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			timer_q  <= 16'h0000;
			result_q <= 16'h0000;
		end
		else if (conv_end)
		begin
			timer_q  <= int_end ? cyc_q + 16'h0001 : cyc_q;
			result_q <= conv_data_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			done_q <= 1'b0;
		else
			done_q <= conv_end;
	end

	// writable registers; result and timer addresses fall through
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			cmd_q   <= LSR_CMD_RESET;
			ctrl_q  <= LSR_CTRL_RESET;
			upper_q <= LSR_UPPER_RESET;
			lower_q <= LSR_LOWER_RESET;
		end
		else if (plain_wr)
		begin
			case (reg_addr_i)
				LSR_ADDR_CMD:   cmd_q   <= reg_wdata_i;
				LSR_ADDR_CTRL:  ctrl_q  <= reg_wdata_i[3:0];
				LSR_ADDR_UPPER: upper_q <= reg_wdata_i;
				LSR_ADDR_LOWER: lower_q <= reg_wdata_i;
				default:        ;
			endcase
		end
	end

	// window check against widened limits
	assign upper_lim = {upper_q, LSR_LIMIT_LOW_BYTE};
	assign lower_lim = {lower_q, LSR_LIMIT_LOW_BYTE};
	assign outside   = (conv_data_i > upper_lim) | (conv_data_i < lower_lim);
	assign pers_need = pers_count(ctrl_q[LSR_CTRL_PERS_LO +: 2]);
	assign trigger   = conv_end & outside & (pers_next >= pers_need);

	// a fresh excursion counts from one, a long one saturates at the top count
	always_comb
	begin
		pers_next = 5'd1;
		case (win_q)
			LSR_WIN_IDLE:
				pers_next = 5'd1;
			LSR_WIN_COUNT,
			LSR_WIN_FIRED:
				pers_next = (pers_q == LSR_PERS_3) ? pers_q : pers_q + 5'd1;
			default:
				pers_next = 5'd1;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			pers_q <= 5'd0;
		else if (conv_end)
			pers_q <= outside ? pers_next : 5'd0;
	end

	// tracks whether the latest readings lie outside the window
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			win_q <= LSR_WIN_IDLE;
		else
		begin
			case (win_q)
				LSR_WIN_IDLE:
					if (conv_end & outside)
						win_q <= trigger ? LSR_WIN_FIRED : LSR_WIN_COUNT;
				LSR_WIN_COUNT:
					if (conv_end)
						win_q <= ~outside ? LSR_WIN_IDLE
						         : (trigger ? LSR_WIN_FIRED : LSR_WIN_COUNT);
				LSR_WIN_FIRED:
					if (conv_end & ~outside)
						win_q <= LSR_WIN_IDLE;
				default:
					win_q <= LSR_WIN_IDLE;
			endcase
		end
	end

	// set beats any clear in the same cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			flag_q <= 1'b0;
		else if (trigger)
			flag_q <= 1'b1;
		else if (clear_wr)
			flag_q <= 1'b0;
		else if (ctrl_clr)
			flag_q <= 1'b0;
	end

	// registered read data
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			rdata_q <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				LSR_ADDR_CMD:    rdata_q <= cmd_q;
				LSR_ADDR_CTRL:   rdata_q <= {2'b00, flag_q, 1'b0, ctrl_q};
				LSR_ADDR_UPPER:  rdata_q <= upper_q;
				LSR_ADDR_LOWER:  rdata_q <= lower_q;
				LSR_ADDR_RES_LO: rdata_q <= result_q[7:0];
				LSR_ADDR_RES_HI: rdata_q <= result_q[15:8];
				LSR_ADDR_CNT_LO: rdata_q <= timer_q[7:0];
				LSR_ADDR_CNT_HI: rdata_q <= timer_q[15:8];
				default:         rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata_o       = rdata_q;
	assign int_pin_o         = 1'b0;
	assign int_pin_oe_n_o    = ~flag_q;
	assign range_const_o     = range_of(ctrl_q[LSR_CTRL_GAIN_LO +: 2]);
	assign full_scale_span_o = ext_mode ? {1'b0, timer_q} : int_len;
	assign conv_done_o       = done_q;

endmodule

//--- rtl/lsr_pkg.sv
// constants for the light sensor register and integration logic
// shared by the core and by the bench that drives its register port
package lsr_pkg;

	localparam logic [7:0] LSR_ADDR_CMD      = 8'h00;
	localparam logic [7:0] LSR_ADDR_CTRL     = 8'h01;
	localparam logic [7:0] LSR_ADDR_UPPER    = 8'h02;
	localparam logic [7:0] LSR_ADDR_LOWER    = 8'h03;
	localparam logic [7:0] LSR_ADDR_RES_LO   = 8'h04;
	localparam logic [7:0] LSR_ADDR_RES_HI   = 8'h05;
	localparam logic [7:0] LSR_ADDR_CNT_LO   = 8'h06;
	localparam logic [7:0] LSR_ADDR_CNT_HI   = 8'h07;

	// address bits that turn a write into a command
	localparam int         LSR_SYNC_BIT      = 7;
	localparam int         LSR_CLEAR_BIT     = 6;

	// command register fields
	localparam int         LSR_CMD_ENABLE    = 7;
	localparam int         LSR_CMD_EXT_TIME  = 5;
	localparam int         LSR_CMD_WIDTH_LO  = 0;

	// control register fields
	localparam int         LSR_CTRL_FLAG     = 5;
	localparam int         LSR_CTRL_GAIN_LO  = 2;
	localparam int         LSR_CTRL_PERS_LO  = 0;

	localparam logic [7:0] LSR_CMD_RESET     = 8'h00;
	localparam logic [3:0] LSR_CTRL_RESET    = 4'h0;
	localparam logic [7:0] LSR_UPPER_RESET   = 8'hff;
	localparam logic [7:0] LSR_LOWER_RESET   = 8'h00;
	localparam logic [7:0] LSR_LIMIT_LOW_BYTE = 8'h00;

	// range constants per gain code
	localparam logic [16:0] LSR_RANGE_0      = 17'd973;
	localparam logic [16:0] LSR_RANGE_1      = 17'd3892;
	localparam logic [16:0] LSR_RANGE_2      = 17'd15568;
	localparam logic [16:0] LSR_RANGE_3      = 17'd62272;

	// oscillator cycles per conversion per width code
	localparam logic [16:0] LSR_LEN_0        = 17'd65536;
	localparam logic [16:0] LSR_LEN_1        = 17'd4096;
	localparam logic [16:0] LSR_LEN_2        = 17'd256;
	localparam logic [16:0] LSR_LEN_3        = 17'd16;

	// consecutive out-of-window integrations per persistence code
	localparam logic [4:0]  LSR_PERS_0       = 5'd1;
	localparam logic [4:0]  LSR_PERS_1       = 5'd4;
	localparam logic [4:0]  LSR_PERS_2       = 5'd8;
	localparam logic [4:0]  LSR_PERS_3       = 5'd16;

	typedef enum logic [1:0]
	{
		LSR_WIN_IDLE  = 2'b00,
		LSR_WIN_COUNT = 2'b01,
		LSR_WIN_FIRED = 2'b11
	} lsr_win_state_t;

endpackage

//--- test/lsr_chk.sv
// port assertions for the light sensor core
// bound to lsr_core from the bench top file
`timescale 1ns/10ps
module lsr_chk
	import lsr_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        int_pin_o,
	input wire logic        int_pin_oe_n_o,
	input wire logic [16:0] range_const_o,
	input wire logic [16:0] full_scale_span_o,
	input wire logic        conv_done_o
);
	function automatic logic [16:0] rng(input logic [7:0] d);
		case (d[3:2])
			2'h0: return LSR_RANGE_0;
			2'h1: return LSR_RANGE_1;
			2'h2: return LSR_RANGE_2;
			default: return LSR_RANGE_3;
		endcase
	endfunction
	function automatic logic [16:0] len(input logic [7:0] d);
		case (d[1:0])
			2'h0: return LSR_LEN_0;
			2'h1: return LSR_LEN_1;
			2'h2: return LSR_LEN_2;
			default: return LSR_LEN_3;
		endcase
	endfunction
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	sequence s_clr;
		reg_wr_i && reg_addr_i[LSR_CLEAR_BIT];
	endsequence
	sequence s_cfg;
		reg_wr_i && reg_addr_i == LSR_ADDR_CTRL;
	endsequence
	sequence s_cmd_int;
		reg_wr_i && reg_addr_i == LSR_ADDR_CMD && !reg_wdata_i[LSR_CMD_EXT_TIME];
	endsequence
	a_rst_outs: assert property (disable iff (1'b0) !rstn_i |=> int_pin_oe_n_o && !conv_done_o)
		else $error("outputs not reset");
	a_pin_drive: assert property (int_pin_o == 1'b0)
		else $error("pin drive not low");
	a_range_map: assert property (s_cfg |=> range_const_o == rng($past(reg_wdata_i)))
		else $error("range constant wrong");
	a_span_len: assert property (s_cmd_int |=> full_scale_span_o == len($past(reg_wdata_i)))
		else $error("span wrong");
	a_cmd_clear: assert property (s_clr |=> int_pin_oe_n_o || conv_done_o)
		else $error("clear ignored");
	a_ctrl_clear: assert property (s_cfg ##0 !reg_wdata_i[LSR_CTRL_FLAG] |=> int_pin_oe_n_o || conv_done_o)
		else $error("flag write ignored");
	a_flag_cause: assert property ($fell(int_pin_oe_n_o) |-> conv_done_o)
		else $error("flag without end");
	a_read_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_unmapped_rd: assert property (reg_rd_i && reg_addr_i > LSR_ADDR_CNT_HI |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule

//--- test/lsr_core_tb.sv
// self-checking bench for lsr_core
// host model drives registers, bench drives oscillator and converter data
`timescale 1ns/10ps
module lsr_core_tb;
	import lsr_pkg::*;
	logic        clk_sys_i;
	logic        rstn_i;
	logic        osc_clk_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic        int_pin_o;
	logic        int_pin_oe_n_o;
	logic        conv_done_o;
	logic [15:0] conv_data_i;
	logic [15:0] d;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic [7:0]  reg_rdata_o;
	logic [7:0]  r;
	logic [7:0]  exp_q[$];
	logic [16:0] range_const_o;
	logic [16:0] full_scale_span_o;
	logic        rd_seen = 1'b0;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          seed = 13;
	int          p, k, n, g;
	int          mt[4] = '{1, 4, 8, 16};
	int          rg[4] = '{973, 3892, 15568, 62272};
	lsr_host h_u (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
	lsr_core dut_u (
		.clk_sys_i         (clk_sys_i),
		.rstn_i            (rstn_i),
		.osc_clk_i         (osc_clk_i),
		.conv_data_i       (conv_data_i),
		.reg_addr_i        (reg_addr_i),
		.reg_wr_i          (reg_wr_i),
		.reg_wdata_i       (reg_wdata_i),
		.reg_rd_i          (reg_rd_i),
		.reg_rdata_o       (reg_rdata_o),
		.int_pin_o         (int_pin_o),
		.int_pin_oe_n_o    (int_pin_oe_n_o),
		.range_const_o     (range_const_o),
		.full_scale_span_o (full_scale_span_o),
		.conv_done_o       (conv_done_o)
	);
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		osc_clk_i = 1'b0;
		#37;
		forever #400 osc_clk_i = ~osc_clk_i;
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0h got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		h_u.acc(1'b0, a, 8'h00);
	endtask
	always @(posedge clk_sys_i)
	begin
		if (rd_seen)
			chk(reg_rdata_o, exp_q.pop_front());
		rd_seen <= reg_rd_i;
	end
	task automatic wait_done(input int lim);
		for (n = 0; n < lim && conv_done_o !== 1'b1; n++)
		begin
			@(posedge clk_sys_i);
			#1;
		end
	endtask
	task automatic sync(input logic [15:0] v);
		conv_data_i = v;
		h_u.sync();
		chk(conv_done_o, 1'b1);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up;
		end
	end
	initial
	begin
		rstn_i = 1'b0;
		conv_data_i = 16'h0800;
		repeat (10) @(posedge clk_sys_i);
		#1;
		rstn_i = 1'b1;
		rd(LSR_ADDR_UPPER, 8'hff);
		rd(LSR_ADDR_LOWER, 8'h00);
		rd(LSR_ADDR_RES_HI, 8'h00);
		rd(8'h10, 8'h00);
		r = 8'($random(seed));
		h_u.acc(1'b1, LSR_ADDR_LOWER, r);
		h_u.acc(1'b1, LSR_ADDR_CNT_LO, 8'h5a);
		rd(LSR_ADDR_LOWER, r);
		rd(LSR_ADDR_CNT_LO, 8'h00);
		for (g = 0; g < 4; g++)
		begin
			h_u.acc(1'b1, LSR_ADDR_CTRL, 8'(g << 2));
			chk(range_const_o, 17'(rg[g]));
			h_u.acc(1'b1, LSR_ADDR_CMD, 8'(g));
			chk(full_scale_span_o, 17'd65536 >> (4 * g));
		end
		$display("register access done");
		h_u.acc(1'b1, LSR_ADDR_CMD, 8'h83);
		chk(full_scale_span_o, 17'd16);
		for (g = 0; g < 4; g += 3)
		begin
			h_u.acc(1'b1, LSR_ADDR_CTRL, 8'(g << 2));
			wait_done(600);
			d = 16'($random(seed));
			conv_data_i = d;
			@(posedge clk_sys_i);
			#1;
			wait_done(600);
			chk(n >= 16 * 8 * (g < 2 ? 2 : 1) - 4 && n <= 16 * 8 * (g < 2 ? 2 : 1) + 2, 1);
			rd(LSR_ADDR_CNT_LO, 8'h10);
			rd(LSR_ADDR_CNT_HI, 8'h00);
			rd(LSR_ADDR_RES_LO, d[7:0]);
			rd(LSR_ADDR_RES_HI, d[15:8]);
		end
		$display("internal timing done");
		h_u.acc(1'b1, LSR_ADDR_CMD, 8'ha0);
		h_u.acc(1'b1, LSR_ADDR_UPPER, 8'h10);
		h_u.acc(1'b1, LSR_ADDR_LOWER, 8'h00);
		for (p = 0; p < 4; p++)
		begin
			h_u.acc(1'b1, LSR_ADDR_CTRL, 8'h0c | 8'(p));
			sync(16'h0800);
			for (k = 0; k < mt[p]; k++)
			begin
				chk(int_pin_oe_n_o, 1'b1);
				d = 16'h1100 | (16'($random(seed)) & 16'h0eff);
				sync(d);
			end
			chk(int_pin_oe_n_o, 1'b0);
			chk(int_pin_o, 1'b0);
			rd(LSR_ADDR_CTRL, 8'h2c | 8'(p));
			rd(LSR_ADDR_RES_LO, d[7:0]);
			rd(LSR_ADDR_RES_HI, d[15:8]);
			h_u.clr();
			chk(int_pin_oe_n_o, 1'b1);
		end
		sync(16'hff01);
		chk(int_pin_oe_n_o, 1'b0);
		repeat (400) @(posedge clk_sys_i);
		#1;
		sync(16'hff02);
		chk(full_scale_span_o >= 17'd49 && full_scale_span_o <= 17'd51, 1'b1);
		rd(LSR_ADDR_CNT_HI, 8'h00);
		h_u.acc(1'b1, LSR_ADDR_CTRL, 8'h23);
		chk(int_pin_oe_n_o, 1'b0);
		h_u.acc(1'b1, LSR_ADDR_CTRL, 8'h03);
		chk(int_pin_oe_n_o, 1'b1);
		sync(16'hff03);
		chk(int_pin_oe_n_o, 1'b0);
		$display("threshold interrupt done");
		rstn_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		rstn_i = 1'b1;
		chk(int_pin_oe_n_o, 1'b1);
		rd(LSR_ADDR_UPPER, 8'hff);
		rd(LSR_ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk_sys_i);
		#1;
		$display("mid-run reset done");
		wrap_up;
	end
endmodule
bind lsr_core lsr_chk chk_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .int_pin_o(int_pin_o), .int_pin_oe_n_o(int_pin_oe_n_o),
	.range_const_o(range_const_o), .full_scale_span_o(full_scale_span_o),
	.conv_done_o(conv_done_o));

//--- test/lsr_host.sv
// host side register master for the light sensor core
// strobes change 1 ns after the rising edge and last one cycle
`timescale 1ns/10ps
module lsr_host
(
	input  wire logic       clk_sys_i,
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_rd_o
);
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = w;
		reg_rd_o = !w;
		@(posedge clk_sys_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		// released bus shows no stale value
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	task automatic sync();
		acc(1'b1, 8'h80, 8'h00);
	endtask
	task automatic clr();
		acc(1'b1, 8'h40, 8'h00);
	endtask
endmodule
